// ==== ibc_params.svh ====
// Purpose: register indices, field positions, reset values and counts
// Assumes: 32-bit register bus, each register one aligned word at index*4
// Notes: definitions only
`ifndef IBC_PARAMS_SVH
`define IBC_PARAMS_SVH

// ****************************************
// register indices (byte address = index*4)
// ****************************************
`define IBC_IDX_CMD_CTRL 6'h04
`define IBC_IDX_DBG_CTRL 6'h08
`define IBC_IDX_BAUD 6'h0A
`define IBC_IDX_IEN_CLR 6'h0C
`define IBC_IDX_IEN_SET 6'h0D
`define IBC_IDX_STATUS 6'h0E

// ****************************************
// field positions
// ****************************************
`define IBC_ACK_BIT 18
`define IBC_CMD_HI 17
`define IBC_CMD_LO 16
`define IBC_QUICK_BIT 9
`define IBC_SMART_BIT 8
`define IBC_HALT_BIT 0
`define IBC_LOWDIV_HI 15
`define IBC_LOWDIV_LO 8
`define IBC_DIV_HI 7
`define IBC_DIV_LO 0
`define IBC_RD_FLAG_BIT 1
`define IBC_WR_FLAG_BIT 0
`define IBC_SYNC_BIT 2

// ****************************************
// reset values and counts
// ****************************************
`define IBC_RST_CMD_CTRL 32'h0000_0000
`define IBC_RST_DBG_CTRL 8'h00
`define IBC_RST_BAUD 16'h0000
`define IBC_RST_IEN 2'h0
`define IBC_SYNC_W 3
`define IBC_SYNC_CYCLES 3'h3
`define IBC_RESP_OKAY 2'h0
`define IBC_RESP_SLVERR 2'h2

`endif

// ==== ibc_pkg.sv ====
// Purpose: shared types of the two-wire host command and bit-rate block
// Assumes: ibc_params.svh on the include path
// Notes: types only, numbers live in the header
`include "ibc_params.svh"
`default_nettype none

package ibc_pkg;

	typedef enum logic [1:0] {
		IBC_CMD_NONE = 2'b00,
		IBC_CMD_RESTART = 2'b01,
		IBC_CMD_READ = 2'b10,
		IBC_CMD_STOP = 2'b11
	} ibc_cmd_t;

	typedef enum logic [2:0] {
		IBC_SEL_NONE = 3'b000,
		IBC_SEL_CMD = 3'b001,
		IBC_SEL_DBG = 3'b010,
		IBC_SEL_BAUD = 3'b011,
		IBC_SEL_CLR = 3'b100,
		IBC_SEL_SET = 3'b101,
		IBC_SEL_STAT = 3'b110
	} ibc_sel_t;

	typedef enum logic {
		IBC_PH_LOW = 1'b0,
		IBC_PH_HIGH = 1'b1
	} ibc_phase_t;

	typedef struct packed {
		ibc_phase_t phase;
		logic [8:0] cnt;
		logic tick;
	} ibc_gen_t;

	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic ack_action;
		logic quick_en;
		logic smart_en;
		logic halt_dbg;
		logic [7:0] div;
		logic [7:0] low_div;
		logic [1:0] irq_en;
		logic rd_flag;
		logic wr_flag;
		logic sync_busy;
		logic [`IBC_SYNC_W-1:0] sync_cnt;
		logic ack_send;
		logic ack_value;
		logic restart;
		logic read_next;
		logic stop;
		logic [1:0] halt_sync;
	} ibc_core_t;

endpackage : ibc_pkg

`default_nettype wire

// ==== ibc_scl_gen.sv ====
// Purpose: SCL high/low period generator driven by the divider fields
// Assumes: run is a same-clock level; periods are divider+1 cycles
// Notes: holds its phase while run is low
`include "ibc_params.svh"
`default_nettype none

module ibc_scl_gen (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [7:0] div,
	input wire logic [7:0] low_div,
	// outputs
	output logic scl_low,
	output logic phase_tick
);
	import ibc_pkg::*;

	ibc_gen_t state_reg;
	ibc_gen_t state_next;
	logic [8:0] limit;

	// ****************************************
	// period selection
	// ****************************************
	always_comb begin
		if (state_reg.phase == IBC_PH_LOW && low_div != 8'h00) begin
			limit = {1'b0, low_div};
		end else begin
			limit = {1'b0, div};
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		// a halted generator keeps its count so the bit resumes where it stopped
		if (run) begin
			if (state_reg.cnt >= limit) begin
				state_next.cnt = 9'h000;
				state_next.tick = 1'b1;
				state_next.phase = (state_reg.phase == IBC_PH_LOW) ? IBC_PH_HIGH : IBC_PH_LOW;
			end else begin
				state_next.cnt = state_reg.cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= '{phase: IBC_PH_LOW, cnt: 9'h000, tick: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign scl_low = (state_reg.phase == IBC_PH_LOW);
	assign phase_tick = state_reg.tick;

endmodule : ibc_scl_gen

`default_nettype wire

// ==== ibc_host_ctrl.sv ====
// Purpose: command, acknowledge, smart read, byte flags, sync busy, bit rate and irq enables
// Assumes: bus engine events arrive as same-clock pulses; debug halt is asynchronous
// Notes: registers over AXI4-Lite, one write and one read outstanding
`include "ibc_params.svh"
`default_nettype none

module ibc_host_ctrl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// neighbouring controller logic
	input wire logic ctrl_enable,
	input wire logic host_read_dir,
	input wire logic byte_rx_ok,
	input wire logic byte_tx_done,
	input wire logic addr_write,
	input wire logic data_write,
	input wire logic data_read,
	// debugger
	input wire logic dbg_halted,
	// bus engine controls
	output logic ack_action,
	output logic ack_send,
	output logic ack_value,
	output logic cmd_restart,
	output logic cmd_read_next,
	output logic cmd_stop,
	output logic quick_transfer_enable,
	output logic smart_read_ack_enable,
	output logic host_read_byte_flag,
	output logic host_write_byte_flag,
	output logic sync_system_op,
	output logic [1:0] irq_enable,
	output logic scl_low,
	output logic scl_phase_tick
);
	import ibc_pkg::*;

	ibc_core_t st_reg;
	ibc_core_t st_next;
	logic gen_run;

	// ****************************************
	// helpers
	// ****************************************
	function automatic ibc_sel_t ibc_decode(input logic [7:0] addr);
		ibc_sel_t sel;
		sel = IBC_SEL_NONE;
		if (addr[1:0] == 2'b00) begin
			unique case (addr[7:2])
				`IBC_IDX_CMD_CTRL: sel = IBC_SEL_CMD;
				`IBC_IDX_DBG_CTRL: sel = IBC_SEL_DBG;
				`IBC_IDX_BAUD: sel = IBC_SEL_BAUD;
				`IBC_IDX_IEN_CLR: sel = IBC_SEL_CLR;
				`IBC_IDX_IEN_SET: sel = IBC_SEL_SET;
				`IBC_IDX_STATUS: sel = IBC_SEL_STAT;
				default: sel = IBC_SEL_NONE;
			endcase
		end
		return sel;
	endfunction : ibc_decode

	function automatic logic [31:0] ibc_read_word(input ibc_core_t s, input ibc_sel_t sel);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (sel)
			IBC_SEL_CMD: begin
				// command field reads zero
				w[`IBC_ACK_BIT] = s.ack_action;
				w[`IBC_QUICK_BIT] = s.quick_en;
				w[`IBC_SMART_BIT] = s.smart_en;
			end
			IBC_SEL_DBG: w[`IBC_HALT_BIT] = s.halt_dbg;
			IBC_SEL_BAUD: begin
				w[`IBC_LOWDIV_HI:`IBC_LOWDIV_LO] = s.low_div;
				w[`IBC_DIV_HI:`IBC_DIV_LO] = s.div;
			end
			IBC_SEL_CLR, IBC_SEL_SET: begin
				w[`IBC_RD_FLAG_BIT] = s.irq_en[1];
				w[`IBC_WR_FLAG_BIT] = s.irq_en[0];
			end
			IBC_SEL_STAT: begin
				w[`IBC_RD_FLAG_BIT] = s.rd_flag;
				w[`IBC_WR_FLAG_BIT] = s.wr_flag;
				w[`IBC_SYNC_BIT] = s.sync_busy;
			end
			IBC_SEL_NONE: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : ibc_read_word

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		ibc_sel_t wsel;
		ibc_sel_t rsel;
		ibc_cmd_t cmd;
		logic clr_flags;
		logic cmd_ok;
		logic ack_now;
		wsel = IBC_SEL_NONE;
		rsel = IBC_SEL_NONE;
		cmd = IBC_CMD_NONE;
		clr_flags = 1'b0;
		cmd_ok = 1'b0;
		ack_now = st_reg.ack_action;
		st_next = st_reg;
		st_next.ack_send = 1'b0;
		st_next.restart = 1'b0;
		st_next.read_next = 1'b0;
		st_next.stop = 1'b0;
		st_next.halt_sync = {st_reg.halt_sync[0], dbg_halted};

		// write channel capture, either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// write execution once both halves are held
		if (st_reg.aw_got && st_reg.w_got) begin
			wsel = ibc_decode(st_reg.aw_addr);
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = (wsel == IBC_SEL_NONE) ? `IBC_RESP_SLVERR : `IBC_RESP_OKAY;
			unique case (wsel)
				IBC_SEL_CMD: begin
					if (st_reg.w_strb[2]) begin
						// acknowledge bit lands first so the command uses it
						ack_now = st_reg.w_data[`IBC_ACK_BIT];
						st_next.ack_action = ack_now;
						cmd = ibc_cmd_t'(st_reg.w_data[`IBC_CMD_HI:`IBC_CMD_LO]);
					end
					if (st_reg.w_strb[1] && !ctrl_enable) begin
						st_next.quick_en = st_reg.w_data[`IBC_QUICK_BIT];
						st_next.smart_en = st_reg.w_data[`IBC_SMART_BIT];
					end
				end
				IBC_SEL_DBG: begin
					if (st_reg.w_strb[0]) begin
						st_next.halt_dbg = st_reg.w_data[`IBC_HALT_BIT];
					end
				end
				IBC_SEL_BAUD: begin
					// divider is enable-protected
					if (st_reg.w_strb[0] && !ctrl_enable) begin
						st_next.div = st_reg.w_data[`IBC_DIV_HI:`IBC_DIV_LO];
					end
					if (st_reg.w_strb[1] && !ctrl_enable) begin
						st_next.low_div = st_reg.w_data[`IBC_LOWDIV_HI:`IBC_LOWDIV_LO];
					end
				end
				IBC_SEL_CLR: begin
					if (st_reg.w_strb[0]) begin
						st_next.irq_en = st_reg.irq_en & ~st_reg.w_data[`IBC_RD_FLAG_BIT:`IBC_WR_FLAG_BIT];
					end
				end
				IBC_SEL_SET: begin
					if (st_reg.w_strb[0]) begin
						st_next.irq_en = st_reg.irq_en | st_reg.w_data[`IBC_RD_FLAG_BIT:`IBC_WR_FLAG_BIT];
					end
				end
				IBC_SEL_STAT, IBC_SEL_NONE: begin
					st_next.bresp = st_next.bresp;
				end
			endcase
		end

		// command execution
		cmd_ok = (cmd != IBC_CMD_NONE) && (st_reg.rd_flag || st_reg.wr_flag);
		if (cmd_ok) begin
			st_next.sync_busy = 1'b1;
			st_next.sync_cnt = `IBC_SYNC_CYCLES;
			st_next.ack_value = ack_now;
			unique case (cmd)
				IBC_CMD_RESTART: begin
					st_next.ack_send = host_read_dir;
					st_next.restart = 1'b1;
					clr_flags = 1'b1;
				end
				IBC_CMD_READ: begin
					if (host_read_dir) begin
						st_next.ack_send = 1'b1;
						st_next.read_next = 1'b1;
						clr_flags = 1'b1;
					end
				end
				IBC_CMD_STOP: begin
					st_next.ack_send = host_read_dir;
					st_next.stop = 1'b1;
					clr_flags = 1'b1;
				end
				IBC_CMD_NONE: clr_flags = 1'b0;
			endcase
		end else if (st_reg.sync_busy) begin
			if (st_reg.sync_cnt == '0) begin
				st_next.sync_busy = 1'b0;
			end else begin
				st_next.sync_cnt = st_reg.sync_cnt - `IBC_SYNC_W'(1);
			end
		end

		// smart-mode read sends the acknowledge without a command
		if (data_read && st_reg.smart_en && st_reg.rd_flag && host_read_dir && !cmd_ok) begin
			st_next.ack_send = 1'b1;
			st_next.ack_value = ack_now;
			clr_flags = 1'b1;
		end

		// byte flags: releases first, then sets, so a new event is never lost
		if (clr_flags || addr_write || data_write) begin
			st_next.rd_flag = 1'b0;
			st_next.wr_flag = 1'b0;
		end
		if (byte_rx_ok) begin
			st_next.rd_flag = 1'b1;
		end
		if (byte_tx_done) begin
			st_next.wr_flag = 1'b1;
		end

		// read channel
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rsel = ibc_decode(s_axi_araddr);
			st_next.rvalid = 1'b1;
			st_next.rdata = ibc_read_word(st_reg, rsel);
			st_next.rresp = (rsel == IBC_SEL_NONE) ? `IBC_RESP_SLVERR : `IBC_RESP_OKAY;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.ack_action <= 1'(`IBC_RST_CMD_CTRL >> `IBC_ACK_BIT);
			st_reg.halt_dbg <= 1'(`IBC_RST_DBG_CTRL >> `IBC_HALT_BIT);
			st_reg.div <= 8'(`IBC_RST_BAUD >> `IBC_DIV_LO);
			st_reg.low_div <= 8'(`IBC_RST_BAUD >> `IBC_LOWDIV_LO);
			st_reg.irq_en <= `IBC_RST_IEN;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// bit-rate generator
	// ****************************************
	// clock stretch: either flag stops the generator, holding SCL in its current phase
	assign gen_run = ctrl_enable && !(st_reg.halt_dbg && st_reg.halt_sync[1])
		&& !st_reg.rd_flag && !st_reg.wr_flag;

	ibc_scl_gen u_scl_gen (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(gen_run),
		.div(st_reg.div),
		.low_div(st_reg.low_div),
		.scl_low(scl_low),
		.phase_tick(scl_phase_tick)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign ack_action = st_reg.ack_action;
	assign ack_send = st_reg.ack_send;
	assign ack_value = st_reg.ack_value;
	assign cmd_restart = st_reg.restart;
	assign cmd_read_next = st_reg.read_next;
	assign cmd_stop = st_reg.stop;
	assign quick_transfer_enable = st_reg.quick_en;
	assign smart_read_ack_enable = st_reg.smart_en;
	assign host_read_byte_flag = st_reg.rd_flag;
	assign host_write_byte_flag = st_reg.wr_flag;
	assign sync_system_op = st_reg.sync_busy;
	assign irq_enable = st_reg.irq_en;

endmodule : ibc_host_ctrl

`default_nettype wire

// ==== ibc_host_ctrl_properties.sv ====
// Purpose: port checks of ibc_host_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`default_nettype none

module ibc_host_ctrl_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// watched inputs
	input wire logic host_read_dir,
	input wire logic byte_rx_ok,
	input wire logic byte_tx_done,
	input wire logic data_read,
	// watched outputs
	input wire logic ack_action,
	input wire logic ack_send,
	input wire logic ack_value,
	input wire logic cmd_restart,
	input wire logic cmd_read_next,
	input wire logic cmd_stop,
	input wire logic smart_read_ack_enable,
	input wire logic host_read_byte_flag,
	input wire logic host_write_byte_flag,
	input wire logic sync_system_op
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	wire any_cmd = cmd_restart | cmd_read_next | cmd_stop;
	wire any_flag = host_read_byte_flag | host_write_byte_flag;

	// ****
	// assertions
	// ****
	a_ack_value: assert property (ack_send |-> ack_value == ack_action)
		else $error("acknowledge value differs from stored bit");
	a_ack_read_dir: assert property (ack_send |-> $past(host_read_dir))
		else $error("acknowledge sent in write direction");
	a_read_next_dir: assert property (cmd_read_next |-> $past(host_read_dir))
		else $error("byte read started in write direction");
	a_cmd_needs_flag: assert property ((any_cmd | ack_send) |-> $past(any_flag))
		else $error("bus action without a byte flag");
	a_cmd_sets_sync: assert property (any_cmd |-> sync_system_op)
		else $error("command without busy bit");
	a_sync_span: assert property ($rose(sync_system_op) |-> sync_system_op [*3] ##[1:6] !sync_system_op)
		else $error("busy bit span wrong");
	a_cmd_releases: assert property (any_cmd && !$past(byte_rx_ok) && !$past(byte_tx_done) |-> !any_flag)
		else $error("command left a byte flag set");
	a_rx_sets_flag: assert property (byte_rx_ok |=> host_read_byte_flag)
		else $error("read flag not set");
	a_tx_sets_flag: assert property (byte_tx_done |=> host_write_byte_flag)
		else $error("write flag not set");
	a_smart_ack: assert property (
		data_read && smart_read_ack_enable && host_read_byte_flag && host_read_dir |=> ack_send)
		else $error("smart read sent no acknowledge");
	c_stop: cover property (cmd_stop);
	c_read_next: cover property (cmd_read_next);
	c_nack: cover property (ack_send && ack_value);
endmodule : ibc_host_ctrl_properties

`default_nettype wire

// ==== ibc_bus_peer.sv ====
// Purpose: far-side bus engine and target model
// Assumes: answers each address, restart or read-next command with one byte event; stop gets none
// Notes: slow stretches the answer to nine cycles
`default_nettype none

module ibc_bus_peer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// from the host side
	input wire logic rd_dir,
	input wire logic addr_sent,
	input wire logic cmd_restart,
	input wire logic cmd_read_next,
	input wire logic slow,
	// byte events
	output logic byte_rx_ok,
	output logic byte_tx_done
);
	logic [3:0] wait_cnt;
	logic rx_pend;

	always_ff @(posedge sys_clk) begin
		byte_rx_ok <= 1'b0;
		byte_tx_done <= 1'b0;
		if (!rst_n) begin
			wait_cnt <= 4'h0;
			rx_pend <= 1'b0;
		end else if (addr_sent | cmd_restart | cmd_read_next) begin
			wait_cnt <= slow ? 4'h9 : 4'h1;
			// restart resends the address, so a write-type event follows
			rx_pend <= cmd_read_next | (addr_sent & rd_dir);
		end else if (wait_cnt == 4'h1) begin
			wait_cnt <= 4'h0;
			byte_rx_ok <= rx_pend;
			byte_tx_done <= !rx_pend;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
	end
endmodule : ibc_bus_peer

`default_nettype wire

// ==== ibc_host_ctrl_tb.sv ====
// Purpose: self-checking bench of ibc_host_ctrl
// Assumes: byte address is register index times four
// Notes: random values from a fixed xorshift seed
`default_nettype none

module ibc_host_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ADR [6] = '{8'h10, 8'h20, 8'h28, 8'h30, 8'h34, 8'h3C};
	logic sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, wr_seen;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd_data, r;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, irq_enable, rd_resp, wr_resp, qs, en;
	logic ctrl_enable, host_read_dir, byte_rx_ok, byte_tx_done, addr_write, data_write, data_read, dbg_halted, slow;
	logic ack_action, ack_send, ack_value, cmd_restart, cmd_read_next, cmd_stop, quick_transfer_enable;
	logic smart_read_ack_enable, host_read_byte_flag, host_write_byte_flag, sync_system_op, scl_low;
	logic scl_phase_tick, tog, sv;
	logic [15:0] bd;
	int error_cnt, n_tests;

	ibc_host_ctrl i_ibc_host_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .ctrl_enable(ctrl_enable), .host_read_dir(host_read_dir),
		.byte_rx_ok(byte_rx_ok), .byte_tx_done(byte_tx_done), .addr_write(addr_write), .data_write(data_write),
		.data_read(data_read), .dbg_halted(dbg_halted), .ack_action(ack_action), .ack_send(ack_send),
		.ack_value(ack_value), .cmd_restart(cmd_restart), .cmd_read_next(cmd_read_next), .cmd_stop(cmd_stop),
		.quick_transfer_enable(quick_transfer_enable), .smart_read_ack_enable(smart_read_ack_enable),
		.host_read_byte_flag(host_read_byte_flag), .host_write_byte_flag(host_write_byte_flag),
		.sync_system_op(sync_system_op), .irq_enable(irq_enable), .scl_low(scl_low),
		.scl_phase_tick(scl_phase_tick));
	ibc_bus_peer i_ibc_bus_peer (.sys_clk(sys_clk), .rst_n(rst_n), .rd_dir(host_read_dir),
		.addr_sent(addr_write), .cmd_restart(cmd_restart), .cmd_read_next(cmd_read_next), .slow(slow),
		.byte_rx_ok(byte_rx_ok), .byte_tx_done(byte_tx_done));

	// ****
	// helpers
	// ****
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [7:0] exp_cmd(input logic rd, input logic [1:0] c, input logic ack);
		logic a;
		logic keep;
		a = rd && c != 2'h0;
		keep = c == 2'h0 || (c == 2'h2 && !rd);
		return {a, a & ack, c == 2'h1, c == 2'h2 && rd, c == 2'h3, c != 2'h0, keep & rd, keep & !rd};
	endfunction : exp_cmd

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_left, w_left;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_left = 1'b1;
		w_left = 1'b1;
		// each half drops only at the edge that takes it
		while (aw_left | w_left) begin
			@(posedge sys_clk);
			if (aw_left && s_axi_awready) begin
				aw_left = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_left && s_axi_wready) begin
				w_left = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
		wr_resp = s_axi_bresp;
		wr_seen = {ack_send, ack_send & ack_value, cmd_restart, cmd_read_next, cmd_stop, sync_system_op,
			host_read_byte_flag, host_write_byte_flag};
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// address write gives the peer a byte to answer with a flag
	task automatic kick(input logic rd);
		host_read_dir <= rd;
		addr_write <= 1'b1;
		@(posedge sys_clk);
		addr_write <= 1'b0;
		repeat (2) @(posedge sys_clk);
		for (int k = 0; k < 20 && !(host_read_byte_flag | host_write_byte_flag); k++) @(posedge sys_clk);
	endtask : kick

	task automatic scl_len(input logic [8:0] lo_x, input logic [8:0] hi_x);
		logic [8:0] lo, hi, tk;
		lo = 9'h0;
		hi = 9'h0;
		tk = 9'h0;
		@(posedge sys_clk);
		while (scl_low) @(posedge sys_clk);
		while (!scl_low) @(posedge sys_clk);
		while (scl_low) begin
			lo++;
			tk += {8'h0, scl_phase_tick};
			@(posedge sys_clk);
		end
		while (!scl_low) begin
			hi++;
			tk += {8'h0, scl_phase_tick};
			@(posedge sys_clk);
		end
		chk(lo, lo_x);
		chk(hi, hi_x);
		chk(tk, 9'h2);
	endtask : scl_len

	task automatic results();
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// ****
	// stimulus
	// ****
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		#600000;
		error_cnt++;
		results();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{rst_n, ctrl_enable, host_read_dir, addr_write, data_write, data_read, dbg_halted, slow} = 8'h0;
		seed = 32'h00015B33;
		en = 2'h0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			axi_rd(ADR[i]);
			chk({rd_resp, rd_data}, (i == 5) ? 34'h200000000 : 34'h0);
		end
		for (int i = 0; i < 3; i++) begin
			r = xs();
			bd = {(i == 1) ? 8'h00 : {4'h0, r[11:8]}, 4'h0, r[3:0]};
			ctrl_enable <= 1'b0;
			axi_wr(8'h28, {16'h0, bd}, 4'h3);
			ctrl_enable <= 1'b1;
			scl_len(((bd[15:8] != 8'h0) ? bd[15:8] : bd[7:0]) + 9'h1, bd[7:0] + 9'h1);
			axi_wr(8'h28, {16'h0, ~bd}, 4'h3);
			axi_rd(8'h28);
			chk(rd_data, bd);
			axi_wr(8'h20, {31'h0, i[0]}, 4'h1);
			dbg_halted <= 1'b1;
			repeat (4) @(posedge sys_clk);
			sv = scl_low;
			tog = 1'b0;
			repeat (40) begin
				@(posedge sys_clk);
				tog = tog | (scl_low != sv);
			end
			chk(tog, !i[0]);
			dbg_halted <= 1'b0;
		end
		// unmapped write answers an error and leaves the enables alone
		axi_wr(8'h3C, 32'hFFFF_FFFF, 4'hF);
		chk({wr_resp, irq_enable}, 4'h8);
		for (int i = 0; i < 8; i++) begin
			r = xs();
			axi_wr(r[2] ? 8'h34 : 8'h30, {30'h0, r[1:0]}, 4'h1);
			en = r[2] ? (en | r[1:0]) : (en & ~r[1:0]);
			axi_rd(8'h30);
			chk(rd_data, en);
			axi_rd(8'h34);
			chk(rd_data, en);
			chk(irq_enable, en);
		end
		r = xs();
		qs = r[9:8];
		ctrl_enable <= 1'b0;
		axi_wr(8'h10, {22'h0, qs, 8'h0}, 4'h2);
		chk({quick_transfer_enable, smart_read_ack_enable}, qs);
		ctrl_enable <= 1'b1;
		axi_wr(8'h10, {22'h0, ~qs, 8'h0}, 4'h2);
		chk({quick_transfer_enable, smart_read_ack_enable}, qs);
		for (int i = 0; i < 8; i++) begin
			r = xs();
			slow <= r[4];
			kick(i[2]);
			chk({host_read_byte_flag, host_write_byte_flag}, i[2] ? 2'h2 : 2'h1);
			axi_wr(8'h10, {13'h0, r[0], i[1:0], 16'h0}, 4'h4);
			chk({wr_resp, wr_seen}, {2'h0, exp_cmd(i[2], i[1:0], r[0])});
			axi_rd(8'h10);
			chk(rd_data, {13'h0, r[0], 8'h0, qs, 8'h0});
			repeat (12) @(posedge sys_clk);
			// a no-action command kept the flag, so a data write must drop it
			if (i[1:0] == 2'h0) begin
				data_write <= 1'b1;
				@(posedge sys_clk);
				data_write <= 1'b0;
				@(posedge sys_clk);
				chk({host_read_byte_flag, host_write_byte_flag}, 2'h0);
			end
			if (i[1:0] == 2'h3) begin
				axi_wr(8'h10, 32'h00010000, 4'h4);
				chk(wr_seen, 8'h0);
			end
		end
		for (int s = 0; s < 2; s++) begin
			ctrl_enable <= 1'b0;
			axi_wr(8'h10, {23'h0, s[0], 8'h0}, 4'h2);
			ctrl_enable <= 1'b1;
			kick(1'b1);
			data_read <= 1'b1;
			@(posedge sys_clk);
			data_read <= 1'b0;
			@(posedge sys_clk);
			chk({ack_send, host_read_byte_flag}, {s[0], !s[0]});
		end
		results();
	end
endmodule : ibc_host_ctrl_tb

bind ibc_host_ctrl ibc_host_ctrl_properties i_ibc_host_ctrl_properties (.sys_clk(sys_clk), .rst_n(rst_n),
	.host_read_dir(host_read_dir), .byte_rx_ok(byte_rx_ok), .byte_tx_done(byte_tx_done), .data_read(data_read),
	.ack_action(ack_action), .ack_send(ack_send), .ack_value(ack_value), .cmd_restart(cmd_restart),
	.cmd_read_next(cmd_read_next), .cmd_stop(cmd_stop), .smart_read_ack_enable(smart_read_ack_enable),
	.host_read_byte_flag(host_read_byte_flag), .host_write_byte_flag(host_write_byte_flag),
	.sync_system_op(sync_system_op));

`default_nettype wire
